// ==== hw/uar_fifo.sv ====
// Synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
module uar_fifo #(
  parameter int unsigned WIDTH = 12,
  parameter int unsigned DEPTH = 16
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] store [DEPTH];
  logic [AW:0] wrPtr;
  logic [AW:0] rdPtr;
  logic push;
  logic pop;

  assign inReady = (wrPtr - rdPtr) != (AW+1)'(DEPTH);
  assign outValid = wrPtr != rdPtr;
  assign push = inValid && inReady;
  assign pop = outValid && outReady;
  assign outData = store[rdPtr[AW-1:0]];

  always_ff @(posedge clock)
  begin
    if (push)
    begin
      store[wrPtr[AW-1:0]] <= inData;
    end
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wrPtr <= '0;
      rdPtr <= '0;
    end
    else
    begin
      if (push)
      begin
        wrPtr <= wrPtr + 1'b1;
      end
      if (pop)
      begin
        rdPtr <= rdPtr + 1'b1;
      end
    end
  end
endmodule : uar_fifo

// ==== hw/uar_pkg.sv ====
// Constants for the asynchronous receive front end
package uar_pkg;
  localparam int unsigned SAMPLES_NORMAL = 16;
  localparam int unsigned SAMPLES_DOUBLE = 8;
  localparam logic [3:0] VOTE_FIRST_NORMAL = 4'h8;
  localparam logic [3:0] VOTE_FIRST_DOUBLE = 4'h4;
  localparam logic [3:0] LAST_STATE_NORMAL = 4'hf;
  localparam logic [3:0] LAST_STATE_DOUBLE = 4'h7;
  localparam logic [3:0] MIN_FRAME_BITS = 4'h5;
  localparam logic [3:0] MAX_FRAME_BITS = 4'ha;
  localparam int unsigned FRAME_WORD_WIDTH = 12;
  localparam int unsigned FIFO_DEPTH = 16;
  typedef enum logic [1:0] {UAR_IDLE, UAR_START, UAR_BITS, UAR_STOP} uar_state_type;
endpackage : uar_pkg

// ==== hw/uar_rx.sv ====
// Asynchronous receive front end: clock and data recovery
`timescale 1ns/1ps
// How it works
// R1: Sample line at 16 ticks per bit normally, 8 in double speed.
// R2: A high-to-low change starts detection; first low sample is number one.
// R3: Start qualified by samples 8,9,10 normally or 4,5,6 in double speed.
// R4: Two or more high qualifying samples reject start as noise; search resumes.
// R5: Valid start realigns bit timing, anew for every frame.
// R6: Per-bit state counter of 16 or 8 states numbers each sample.
// R7: Each bit is the majority of its three centre samples.
// R8: Votes at samples 8,9,10 normally or 4,5,6 in double speed.
// R9: Recover every bit through first stop bit; later stop bits are ignored.
// R10: Stop bit voted as zero sets frame error for that frame.
// R11: Next start edge accepted right after the last stop voting sample.
// R12: Double speed selected when double_speed_select is one.
// R13: Data plus parity bit count from five to ten.
// R14: Remote transmitter should keep rate error near half the tolerance.
// R15: Frame error is stored in the buffer with its frame.
// R16: Optional parity check, odd or even, over recovered data bits.
// R17: Input synchronised by two flops; sampling advances on oversample ticks.
module uar_rx
  import uar_pkg::*;
#(
  parameter int unsigned DEPTH = FIFO_DEPTH
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic sampleTick,
  input wire logic serial_receive_pin,
  input wire logic double_speed_select,
  input wire logic [3:0] frameBits,
  input wire logic parity_check_enable,
  input wire logic parity_odd_even_select,
  output logic frameValid,
  input wire logic frameReady,
  output logic [9:0] frameData,
  output logic frame_error_flag,
  output logic parityErrorFlag,
  output logic frameDropped,
  output logic rxBusy
);
  logic syncA;
  logic syncB;
  logic lineLast;
  uar_state_type state;
  logic [3:0] sampleNum;
  logic [3:0] bitIndex;
  logic [2:0] votes;
  logic [9:0] shiftData;
  logic [3:0] lenLatched;
  logic dblLatched;
  logic voteBit;
  logic [3:0] voteFirst;
  logic [3:0] lastState;
  logic [3:0] lenSafe;
  logic voteDone;
  logic pushValid;
  logic pushReady;
  logic [FRAME_WORD_WIDTH-1:0] pushWord;
  logic [FRAME_WORD_WIDTH-1:0] popWord;
  logic parityCalc;
  logic [3:0] dataBits;
  logic fallEdge;

  // Two flops before any sampling
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      syncA <= 1'b1;
      syncB <= 1'b1;
    end
    else
    begin
      syncA <= serial_receive_pin; // R17
      syncB <= syncA; // R17
    end
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      lineLast <= 1'b1;
    end
    else if (sampleTick)
    begin
      lineLast <= syncB;
    end
  end

  // Out-of-range lengths clamp so a frame always ends
  assign lenSafe = (frameBits < MIN_FRAME_BITS) ? MIN_FRAME_BITS : // R13
    (frameBits > MAX_FRAME_BITS) ? MAX_FRAME_BITS : frameBits;
  assign voteFirst = dblLatched ? VOTE_FIRST_DOUBLE : VOTE_FIRST_NORMAL; // R8
  assign lastState = dblLatched ? LAST_STATE_DOUBLE : LAST_STATE_NORMAL; // R1 R6
  assign voteBit = (votes[0] & votes[1]) | (votes[0] & votes[2]) | (votes[1] & votes[2]); // R7
  assign voteDone = sampleTick && sampleNum == voteFirst + 4'h2;
  assign fallEdge = sampleTick && lineLast && !syncB; // R2

  // Sample capture for the first two centre votes
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      votes <= 3'h0;
    end
    else if (sampleTick && state != UAR_IDLE)
    begin
      if (sampleNum == voteFirst) // R3 R8
      begin
        votes[0] <= syncB;
      end
      if (sampleNum == voteFirst + 4'h1)
      begin
        votes[1] <= syncB;
      end
    end
  end

  // Third vote is taken combinationally in the decision cycle
  logic decided;
  assign decided = (votes[0] & votes[1]) | ((votes[0] | votes[1]) & syncB);

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state <= UAR_IDLE;
      sampleNum <= 4'h0;
      bitIndex <= 4'h0;
      shiftData <= 10'h000;
      lenLatched <= MIN_FRAME_BITS;
      dblLatched <= 1'b0;
      pushValid <= 1'b0;
      pushWord <= '0;
    end
    else
    begin
      pushValid <= 1'b0;
      unique case (state)
        UAR_IDLE:
        begin
          if (fallEdge)
          begin
            state <= UAR_START; // R2
            sampleNum <= 4'h2; // Edge sample is number one
            dblLatched <= double_speed_select; // R12
            lenLatched <= lenSafe; // R13
          end
        end
        UAR_START:
        begin
          if (sampleTick)
          begin
            sampleNum <= sampleNum + 4'h1;
            if (voteDone)
            begin
              if (decided)
              begin
                state <= UAR_IDLE; // R4
                sampleNum <= 4'h0;
              end
              else if (sampleNum == lastState)
              begin
                state <= UAR_BITS;
                sampleNum <= 4'h0;
              end
            end
            if (sampleNum == lastState)
            begin
              state <= UAR_BITS; // R5
              sampleNum <= 4'h0;
              bitIndex <= 4'h0;
            end
          end
        end
        UAR_BITS:
        begin
          if (sampleTick)
          begin
            sampleNum <= (sampleNum == lastState) ? 4'h0 : sampleNum + 4'h1; // R6
            if (voteDone)
            begin
              shiftData[bitIndex] <= decided; // R7
            end
            if (sampleNum == lastState)
            begin
              bitIndex <= bitIndex + 4'h1; // R9
              if (bitIndex + 4'h1 == lenLatched)
              begin
                state <= UAR_STOP;
              end
            end
          end
        end
        UAR_STOP:
        begin
          if (sampleTick)
          begin
            sampleNum <= sampleNum + 4'h1;
            if (voteDone)
            begin
              // Remaining stop length and extra stop bits are not waited for
              state <= UAR_IDLE; // R11 R9
              sampleNum <= 4'h0;
              pushValid <= 1'b1;
              pushWord <= {!decided, parityCalc ^ parityExpect(), shiftData}; // R10 R15 R16
            end
          end
        end
      endcase
    end
  end

  // Parity bit is the last of the counted bits when checking is enabled
  assign dataBits = parity_check_enable ? lenLatched - 4'h1 : lenLatched;
  always_comb
  begin
    parityCalc = parity_odd_even_select;
    for (int i = 0; i < int'(MAX_FRAME_BITS); i++)
    begin
      if (4'(i) < dataBits)
      begin
        parityCalc = parityCalc ^ shiftData[i]; // R16
      end
    end
  end

  function automatic logic parityExpect();
    if (!parity_check_enable)
    begin
      return parityCalc;
    end
    return shiftData[dataBits];
  endfunction : parityExpect

  // Full buffer drops the frame and reports it
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      frameDropped <= 1'b0;
    end
    else
    begin
      frameDropped <= pushValid && !pushReady;
    end
  end

  uar_fifo #(
    .WIDTH(FRAME_WORD_WIDTH),
    .DEPTH(DEPTH)
  ) frameStore (
    .clock(clock),
    .rst_n(rst_n),
    .inValid(pushValid),
    .inReady(pushReady),
    .inData(pushWord),
    .outValid(frameValid),
    .outReady(frameReady),
    .outData(popWord)
  );

  assign frameData = popWord[9:0];
  assign parityErrorFlag = popWord[10];
  assign frame_error_flag = popWord[11]; // R15
  assign rxBusy = state != UAR_IDLE;

  AST_NOISE_REJECT: assert property (@(posedge clock) disable iff (!rst_n)
    state == UAR_START && voteDone && decided |=> state == UAR_IDLE) // R4
    else $error("Noise start not rejected");
  AST_START_ENTRY: assert property (@(posedge clock) disable iff (!rst_n)
    state == UAR_IDLE && fallEdge |=> state == UAR_START && sampleNum == 4'h2) // R2
    else $error("Start detection not begun");
  AST_COUNTER_WRAP: assert property (@(posedge clock) disable iff (!rst_n)
    state == UAR_BITS |-> sampleNum <= lastState) // R6
    else $error("Bit state counter out of range");
  AST_STOP_PUSH: assert property (@(posedge clock) disable iff (!rst_n)
    state == UAR_STOP && voteDone |=> pushValid && state == UAR_IDLE) // R11
    else $error("Stop vote did not end frame");
  AST_FE_VALUE: assert property (@(posedge clock) disable iff (!rst_n)
    state == UAR_STOP && voteDone && !decided |=> pushWord[11]) // R10
    else $error("Frame error not recorded");
  AST_LEN_RANGE: assert property (@(posedge clock) disable iff (!rst_n)
    lenLatched >= MIN_FRAME_BITS && lenLatched <= MAX_FRAME_BITS) // R13
    else $error("Frame length out of range");
  AST_MODE_HOLD: assert property (@(posedge clock) disable iff (!rst_n)
    state != UAR_IDLE && $past(state) != UAR_IDLE |-> $stable(dblLatched)) // R12
    else $error("Speed mode changed mid frame");
  AST_NO_PAR: assert property (@(posedge clock) disable iff (!rst_n)
    pushValid && $past(!parity_check_enable) |-> !pushWord[10]) // R16
    else $error("Parity error without checking");
  COV_FRAME: cover property (@(posedge clock) pushValid && !pushWord[11]);
  COV_FE: cover property (@(posedge clock) pushValid && pushWord[11]);
  COV_NOISE: cover property (@(posedge clock) state == UAR_START && voteDone && decided);
endmodule : uar_rx

// ==== tb/testbench.sv ====
// Self-checking testbench for the receive front end
`timescale 1ns/1ps
module testbench;
  import uar_pkg::*;
  logic clock, rst_n, dblSpeed, parEn, parOdd, frameReady, line;
  logic frameValid, frameErr, parErr, frameDropped, rxBusy;
  logic sampleTick = 1'b0;
  logic lost = 1'b0;
  logic [3:0] frameBits;
  logic [9:0] frameData;
  int n_fail, checked;

  uar_rx u_dut (.clock(clock), .rst_n(rst_n), .sampleTick(sampleTick),
    .serial_receive_pin(line), .double_speed_select(dblSpeed), .frameBits(frameBits),
    .parity_check_enable(parEn), .parity_odd_even_select(parOdd), .frameValid(frameValid),
    .frameReady(frameReady), .frameData(frameData), .frame_error_flag(frameErr),
    .parityErrorFlag(parErr), .frameDropped(frameDropped), .rxBusy(rxBusy));
  uar_tx_model u_tx (.clock(clock), .sampleTick(sampleTick), .line(line));

  initial
  begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  // Tick every other clock keeps the baud generator apart from the clock
  always @(posedge clock)
  begin
    sampleTick <= !sampleTick;
    if (frameDropped === 1'b1)
      lost <= 1'b1;
  end

  task automatic results;
    if (n_fail == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : results

  task automatic chk(input string name, input logic [9:0] exp, input logic [9:0] got);
    checked++;
    if (exp !== got)
    begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic popChk(input logic [9:0] d, input logic fe, input logic pe);
    logic [9:0] mask;
    int i;
    mask = (10'h1 << frameBits) - 10'h1;
    i = 0;
    while (frameValid !== 1'b1 && i < 3000)
    begin
      @(posedge clock);
      i++;
    end
    chk("frameValid", 10'h1, {9'h0, frameValid});
    chk("frameData", d & mask, frameData & mask);
    chk("frameError", {9'h0, fe}, {9'h0, frameErr});
    chk("parityError", {9'h0, pe}, {9'h0, parErr});
    frameReady <= 1'b1;
    @(posedge clock);
    frameReady <= 1'b0;
    @(posedge clock);
  endtask : popChk

  task automatic setMode(input logic d, input logic [3:0] n, input logic pen, input logic po);
    dblSpeed <= d;
    frameBits <= n;
    parEn <= pen;
    parOdd <= po;
    @(posedge clock);
  endtask : setMode

  task automatic tNormal;
    setMode(1'b0, 4'h8, 1'b0, 1'b0);
    u_tx.send(10'h0a5, 8, 1'b1, 16, 16);
    popChk(10'h0a5, 1'b0, 1'b0);
  endtask : tNormal

  task automatic tDouble;
    setMode(1'b1, 4'h5, 1'b0, 1'b0);
    u_tx.send(10'h013, 5, 1'b0, 8, 8);
    popChk(10'h013, 1'b1, 1'b0);
  endtask : tDouble

  task automatic tNoise;
    setMode(1'b0, 4'h8, 1'b0, 1'b0);
    fork
      u_tx.glitch(7);
      begin
        // Before the qualifying window the receiver is already busy
        repeat (12) @(posedge clock);
        chk("rxBusyStart", 10'h1, {9'h0, rxBusy});
      end
    join
    chk("noiseFrame", 10'h0, {9'h0, frameValid});
    chk("rxBusyIdle", 10'h0, {9'h0, rxBusy});
    u_tx.send(10'h05a, 8, 1'b1, 16, 16);
    popChk(10'h05a, 1'b0, 1'b0);
  endtask : tNoise

  task automatic tBackToBack;
    setMode(1'b0, 4'ha, 1'b0, 1'b0);
    u_tx.send(10'h3c5, 10, 1'b1, 16, 10);
    u_tx.send(10'h13a, 10, 1'b1, 16, 10);
    popChk(10'h3c5, 1'b0, 1'b0);
    popChk(10'h13a, 1'b0, 1'b0);
  endtask : tBackToBack

  task automatic tParity;
    setMode(1'b0, 4'h9, 1'b1, 1'b1);
    u_tx.send(10'h101, 9, 1'b1, 16, 16);
    popChk(10'h101, 1'b0, 1'b1);
    setMode(1'b0, 4'h9, 1'b1, 1'b0);
    u_tx.send(10'h101, 9, 1'b1, 16, 16);
    popChk(10'h101, 1'b0, 1'b0);
  endtask : tParity

  // Far side keeps sending while nobody drains the buffer
  task automatic tFull;
    setMode(1'b0, 4'h5, 1'b0, 1'b0);
    for (int i = 0; i <= FIFO_DEPTH; i++)
      u_tx.send(10'(i), 5, i[0], 16, 10);
    repeat (8) @(posedge clock);
    chk("dropped", 10'h1, {9'h0, lost});
    // Even frames carry a low stop bit
    for (int i = 0; i < FIFO_DEPTH; i++)
      popChk(10'(i), !i[0], 1'b0);
    chk("drained", 10'h0, {9'h0, frameValid});
  endtask : tFull

  initial
  begin
    n_fail = 0;
    checked = 0;
    rst_n = 1'b0;
    frameReady = 1'b0;
    dblSpeed = 1'b0;
    frameBits = 4'h8;
    parEn = 1'b0;
    parOdd = 1'b0;
    repeat (5) @(posedge clock);
    rst_n <= 1'b1;
    repeat (4) @(posedge clock);
    tNormal();
    tDouble();
    tNoise();
    tBackToBack();
    tParity();
    tFull();
    results();
  end

  initial
  begin
    repeat (40000) @(posedge clock);
    n_fail++;
    results();
  end
endmodule : testbench

// ==== tb/uar_tx_model.sv ====
// Remote asynchronous transmitter that paces its bits by oversample ticks
`timescale 1ns/1ps
module uar_tx_model (
  input wire logic clock,
  input wire logic sampleTick,
  output logic line
);
  initial line = 1'b1;

  // Exact bit rate, well inside the receiver's tolerance
  task automatic waitTicks(input int n);
    repeat (n)
    begin
      @(posedge clock);
      while (sampleTick !== 1'b1)
        @(posedge clock);
    end
  endtask : waitTicks

  // Short stop lengths model the earliest legal next start
  task automatic send(input logic [9:0] d, input int n, input logic stopVal, input int spb,
    input int stopTicks);
    line <= 1'b0;
    waitTicks(spb);
    for (int i = 0; i < n; i++)
    begin
      line <= d[i];
      waitTicks(spb);
    end
    line <= stopVal;
    waitTicks(stopTicks);
    // A low stop needs a high gap, else the next start has no falling edge
    if (!stopVal)
    begin
      line <= 1'b1;
      waitTicks(2);
    end
  endtask : send

  task automatic glitch(input int lowTicks);
    line <= 1'b0;
    waitTicks(lowTicks);
    line <= 1'b1;
    waitTicks(40);
  endtask : glitch
endmodule : uar_tx_model
